// ### verilog/jbs_pkg.sv
// jbs_pkg: constants, types and helpers shared by the boundary-scan test port.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package jbs_pkg;

    localparam int IR_W = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_CLAMP = 4'h2;
    localparam logic [3:0] IR_HIGHZ = 4'h3;
    localparam logic [3:0] IR_PULSE = 4'h4;
    localparam logic [3:0] IR_TRAIN = 4'h5;
    localparam logic [3:0] IR_IDCODE = 4'h6;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    // value the instruction register takes after a port reset
    localparam logic [3:0] IR_RESET = IR_IDCODE;
    // fixed pattern loaded into the instruction shifter on capture
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    localparam int BSR_LEN = 244;
    localparam int ID_W = 32;
    localparam int NUM_IN = 120;
    localparam int NUM_OUT = 64;
    localparam int NUM_BIDI = 20;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;

    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UP_DR,
        S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UP_IR
    } jbs_state_t;

    typedef enum logic [1:0] {SEL_BSR, SEL_ID, SEL_BYP} jbs_sel_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jbs_pins_t;

    // instruction to data register; every unassigned code falls to bypass
    function automatic jbs_sel_t jbs_decode(input logic [3:0] ir);
        case (ir)
            IR_EXTEST, IR_SAMPLE, IR_PULSE, IR_TRAIN: jbs_decode = SEL_BSR;
            IR_IDCODE: jbs_decode = SEL_ID;
            default: jbs_decode = SEL_BYP;
        endcase
    endfunction

    // standard port controller transition on a tck rising edge
    function automatic jbs_state_t jbs_next(input jbs_state_t s, input logic tms);
        case (s)
            S_TLR: jbs_next = tms ? S_TLR : S_RTI;
            S_RTI: jbs_next = tms ? S_SEL_DR : S_RTI;
            S_SEL_DR: jbs_next = tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: jbs_next = tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR: jbs_next = tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: jbs_next = tms ? S_UP_DR : S_PA_DR;
            S_PA_DR: jbs_next = tms ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: jbs_next = tms ? S_UP_DR : S_SH_DR;
            S_UP_DR: jbs_next = tms ? S_SEL_DR : S_RTI;
            S_SEL_IR: jbs_next = tms ? S_TLR : S_CAP_IR;
            S_CAP_IR: jbs_next = tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR: jbs_next = tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: jbs_next = tms ? S_UP_IR : S_PA_IR;
            S_PA_IR: jbs_next = tms ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: jbs_next = tms ? S_UP_IR : S_SH_IR;
            default: jbs_next = tms ? S_SEL_DR : S_RTI;
        endcase
    endfunction

endpackage

// ### verilog/jbs_sync.sv
// jbs_sync: two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/10ps
module jbs_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // jbs_sync

// ### verilog/jbs_tap.sv
// jbs_tap: boundary-scan test port, instruction decode, data registers, pin muxing.
// Assumes tck/tms/tdi/trst_n and pad inputs are asynchronous to mclk (20 MHz)
// and tck runs well below mclk/4 so every edge is seen; core signals are on mclk.
`timescale 1ns/10ps
module jbs_tap #(
    parameter int NI = jbs_pkg::NUM_IN,
    parameter int NO = jbs_pkg::NUM_OUT,
    parameter int NB = jbs_pkg::NUM_BIDI,
    parameter logic [3:0] ID_VERSION = 4'h3,    // arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234,  // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h2AB   // arbitrary value
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire jbs_pkg::jbs_pins_t tap_pins,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [NI-1:0] pad_in,
    input wire logic [NB-1:0] pad_bidi_i,
    input wire logic [NO-1:0] core_out,
    input wire logic [NB-1:0] core_bidi_o,
    input wire logic [NB-1:0] core_bidi_oe,
    output logic [NI-1:0] core_in,
    output logic [NB-1:0] core_bidi_i,
    output logic [NO-1:0] pad_out,
    output logic [NO-1:0] pad_out_oe,
    output logic [NB-1:0] pad_bidi_o,
    output logic [NB-1:0] pad_bidi_oe
);
    import jbs_pkg::*;

    localparam int N = NI + NO + 3 * NB;
    localparam int OUT_B = NI;
    localparam int BI_B = NI + NO;
    localparam int BO_B = NI + NO + NB;
    localparam int BC_B = NI + NO + 2 * NB;
    localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and tck edges
    jbs_pins_t pins_s;
    logic [NI+NB-1:0] pads_s;
    logic tck_d;
    logic tck_rise;
    logic tck_fall;

    jbs_sync #(.W(4)) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(tap_pins),
        .q(pins_s)
    );

    jbs_sync #(.W(NI + NB)) u_pad_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({pad_bidi_i, pad_in}),
        .q(pads_s)
    );

    // core sees synchronised pads; scan never steers core inputs
    assign core_in = pads_s[NI-1:0];
    assign core_bidi_i = pads_s[NI+NB-1:NI];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tck_d <= 1'b0;
        else
            tck_d <= pins_s.tck;
    end

    assign tck_rise = pins_s.tck & ~tck_d;
    assign tck_fall = ~pins_s.tck & tck_d;

    ////////////////////////////////////////////////////////////////////////////
    // port controller
    jbs_state_t state;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic ir_fresh;
    jbs_sel_t sel;

    assign sel = jbs_decode(ir);

    // trst_n wins over any tck activity
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state <= S_TLR;
        else if (!pins_s.trst_n)
            state <= S_TLR;
        else if (tck_rise)
            state <= jbs_next(state, pins_s.tms);
    end

    // instruction shifter, lsb leaves first
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ir_sh <= IR_CAPTURE;
        else if (tck_rise && state == S_CAP_IR)
            ir_sh <= IR_CAPTURE;
        else if (tck_rise && state == S_SH_IR)
            ir_sh <= {pins_s.tdi, ir_sh[IR_W-1:1]};
    end

    // a real shift since capture-ir; without one the capture pattern must not load
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ir_fresh <= 1'b0;
        else if (tck_rise && state == S_CAP_IR)
            ir_fresh <= 1'b0;
        else if (tck_rise && state == S_SH_IR)
            ir_fresh <= 1'b1;
    end

    // active instruction changes only at update-ir; held at idcode in reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ir <= IR_RESET;
        else if (!pins_s.trst_n || state == S_TLR)
            ir <= IR_RESET;
        else if (tck_rise && state == S_UP_IR)
            ir <= ir_fresh ? ir_sh : IR_RESET;
    end

    ////////////////////////////////////////////////////////////////////////////
    // data registers
    logic [N-1:0] bsr_sh;
    logic [N-1:0] bsr_upd;
    logic [N-1:0] cap_vec;
    logic [ID_W-1:0] id_sh;
    logic byp;

    // cell order from tdo: inputs, outputs, bidi in, bidi out, bidi control
    assign cap_vec = {pad_bidi_oe, pad_bidi_o, pads_s[NI+NB-1:NI], pad_out, pads_s[NI-1:0]};

    // capture snapshots pins without touching them; shift moves toward tdo
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            bsr_sh <= '0;
        else if (tck_rise && sel == SEL_BSR && state == S_CAP_DR)
            bsr_sh <= cap_vec;
        else if (tck_rise && sel == SEL_BSR && state == S_SH_DR)
            bsr_sh <= {pins_s.tdi, bsr_sh[N-1:1]};
    end

    // update latch; only reloaded while the chain is selected, so clamp holds it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            bsr_upd <= '0;
        else if (tck_rise && sel == SEL_BSR && state == S_UP_DR)
            bsr_upd <= bsr_sh;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            id_sh <= '0;
        else if (tck_rise && sel == SEL_ID && state == S_CAP_DR)
            id_sh <= ID_VALUE;
        else if (tck_rise && sel == SEL_ID && state == S_SH_DR)
            id_sh <= {pins_s.tdi, id_sh[ID_W-1:1]};
    end

    // single stage; captures zero as the standard expects
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            byp <= 1'b0;
        else if (tck_rise && sel == SEL_BYP && state == S_CAP_DR)
            byp <= 1'b0;
        else if (tck_rise && sel == SEL_BYP && state == S_SH_DR)
            byp <= pins_s.tdi;
    end

    ////////////////////////////////////////////////////////////////////////////
    // tdo changes on the falling tck edge so the tester samples a settled bit
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe <= (state == S_SH_IR) || (state == S_SH_DR);
            if (state == S_SH_IR)
                tdo <= ir_sh[0];
            else if (sel == SEL_BSR)
                tdo <= bsr_sh[0];
            else if (sel == SEL_ID)
                tdo <= id_sh[0];
            else
                tdo <= byp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin muxing: pulse/train treated as dc extest, ac stimulus is in the pads
    logic drive;
    logic hiz;

    assign drive = (ir == IR_EXTEST) || (ir == IR_PULSE) || (ir == IR_TRAIN) ||
                   (ir == IR_CLAMP);
    assign hiz = (ir == IR_HIGHZ);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_out <= '0;
            pad_out_oe <= '0;
            pad_bidi_o <= '0;
            pad_bidi_oe <= '0;
        end
        else
        begin
            pad_out <= drive ? bsr_upd[OUT_B +: NO] : core_out;
            pad_out_oe <= hiz ? '0 : '1;
            pad_bidi_o <= drive ? bsr_upd[BO_B +: NB] : core_bidi_o;
            pad_bidi_oe <= hiz ? '0 : (drive ? bsr_upd[BC_B +: NB] : core_bidi_oe);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    ir_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pins_s.trst_n |=> (state == S_TLR && ir == IR_RESET))
        else $error("port reset did not restore idcode");

    id_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (tck_rise && state == S_CAP_DR && ir == IR_IDCODE && pins_s.trst_n)
        |=> id_sh == ID_VALUE && id_sh[0])
        else $error("id capture value wrong");

    byp_path_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (tck_rise && state == S_SH_DR && sel == SEL_BYP && pins_s.trst_n)
        |=> byp == $past(pins_s.tdi))
        else $error("bypass stage did not take tdi");

    reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ir == 4'h7 || ir[3]) |-> sel == SEL_BYP)
        else $error("unassigned code not decoded as bypass");

    highz_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hiz |=> (pad_out_oe == '0 && pad_bidi_oe == '0))
        else $error("outputs driven under highz");

    clamp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ir == IR_CLAMP) [*3] |-> $stable(pad_out) && $stable(pad_bidi_o))
        else $error("clamped outputs changed");

    extest_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (drive && ir != IR_CLAMP) |=> pad_out == $past(bsr_upd[OUT_B +: NO]))
        else $error("output pins not driven from cells");

    sample_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ir == IR_SAMPLE) |=> pad_out == $past(core_out))
        else $error("sample disturbed normal outputs");

    ir_update_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(ir) |-> ($past(state) == S_UP_IR || state == S_TLR))
        else $error("instruction changed outside update-ir");

    chain_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (tck_rise && state == S_CAP_DR && sel == SEL_BSR && pins_s.trst_n)
        |=> bsr_sh == $past(cap_vec))
        else $error("chain capture wrong");

    cov_id_c: cover property (@(posedge mclk) disable iff (!rst_n)
        tck_rise && state == S_SH_DR && sel == SEL_ID);
    cov_extest_c: cover property (@(posedge mclk) disable iff (!rst_n)
        ir == IR_EXTEST && tck_rise && state == S_UP_DR);
    cov_highz_c: cover property (@(posedge mclk) disable iff (!rst_n) hiz);
    cov_clamp_c: cover property (@(posedge mclk) disable iff (!rst_n) ir == IR_CLAMP);

endmodule // jbs_tap

// ### bench/jbs_ctl.sv
// jbs_ctl: behavioural board-test controller driving the scan port pins.
// Assumes the bench calls one task at a time; tck rests low between frames.
`timescale 1ns/10ps
module jbs_ctl (
    output jbs_pkg::jbs_pins_t pins,
    input wire logic tdo,
    input wire logic tdo_oe
);
    import jbs_pkg::*;

    // set when the port left tdo undriven during any shifted bit of the last scan
    logic oe_miss = 1'b0;

    // idle levels: controller parked, optional reset released
    initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // one 400 ns tck period; tdo read late in the low phase, where it has settled
    task automatic step(input logic m, input logic d, output logic o);
        pins.tms = m;
        pins.tdi = d;
        #200;
        o = tdo;
        pins.tck = 1'b1;
        #200;
        pins.tck = 1'b0;
    endtask

    // run-test/idle through one scan and back; update lands on the rise into idle
    task automatic scan(input logic ir, input int n, input logic [299:0] din,
        output logic [299:0] dout);
        logic o;
        dout = '0;
        oe_miss = 1'b0;
        #7; // keeps tck edges off a fixed mclk phase
        step(1'b1, 1'b0, o);
        if (ir)
            step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        // lsb first, exit on the last bit
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
            oe_miss |= !tdo_oe;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // five tms ones reach test-logic-reset from any state, then park in idle
    task automatic idle_reset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // asynchronous port reset, long enough for the synchroniser to see it
    task automatic pulse_trst();
        pins.trst_n = 1'b0;
        #400;
        pins.trst_n = 1'b1;
    endtask
endmodule // jbs_ctl

// ### bench/tb.sv
// tb: self-checking bench for the boundary-scan port with random pad levels.
// Assumes jbs_ctl as the far-side controller; no registers or interrupts.
`timescale 1ns/10ps
module tb;
    import jbs_pkg::*;

    localparam logic [31:0] ID_EXP = {4'hA, 16'h5C3E, 11'h155, 1'b1};
    logic mclk, rst_n, tdo, tdo_oe;
    jbs_pins_t tap_pins;
    logic [NUM_IN-1:0] pad_in, core_in;
    logic [NUM_BIDI-1:0] pad_bidi_i, core_bidi_o, core_bidi_oe, core_bidi_i;
    logic [NUM_BIDI-1:0] pad_bidi_o, pad_bidi_oe;
    logic [NUM_OUT-1:0] core_out, pad_out, pad_out_oe;
    logic [31:0] seed = 32'h8D54;
    logic [299:0] din, dout, pre;
    logic bit_seen;
    logic [3:0] drv [3] = '{IR_EXTEST, IR_PULSE, IR_TRAIN};
    int failures = 0;
    int checks_done = 0;

    // id fields are arbitrary values
    jbs_tap #(.ID_VERSION(4'hA), .ID_PART(16'h5C3E), .ID_MAKER(11'h155)) i_dut (
        .mclk(mclk), .rst_n(rst_n), .tap_pins(tap_pins), .tdo(tdo), .tdo_oe(tdo_oe),
        .pad_in(pad_in), .pad_bidi_i(pad_bidi_i), .core_out(core_out),
        .core_bidi_o(core_bidi_o), .core_bidi_oe(core_bidi_oe), .core_in(core_in),
        .core_bidi_i(core_bidi_i), .pad_out(pad_out), .pad_out_oe(pad_out_oe),
        .pad_bidi_o(pad_bidi_o), .pad_bidi_oe(pad_bidi_oe));
    jbs_ctl i_ctl (.pins(tap_pins), .tdo(tdo), .tdo_oe(tdo_oe));

    // 20 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [299:0] rvec();
        logic [319:0] r;
        for (int i = 0; i < 10; i++)
            r[i*32 +: 32] = rnd();
        return r[299:0];
    endfunction

    // serial path length each instruction should give
    function automatic int chain_len(input logic [3:0] c);
        case (c)
            IR_EXTEST, IR_SAMPLE, IR_PULSE, IR_TRAIN: return BSR_LEN;
            IR_IDCODE: return ID_W;
            default: return 1;
        endcase
    endfunction

    task automatic check(input string what, input logic [299:0] seen,
        input logic [299:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // fresh pad and core levels, driven just after an mclk edge
    task automatic new_pins();
        din = rvec();
        @(posedge mclk);
        #2;
        {core_bidi_oe, core_bidi_o, pad_bidi_i, core_out, pad_in} = din[BSR_LEN-1:0];
    endtask

    // instruction load; pads need a few mclk after update to follow
    task automatic load_ir(input logic [3:0] c);
        i_ctl.scan(1'b1, IR_W, {296'h0, c}, dout);
        check("ir capture", dout[3:0], IR_CAPTURE);
        repeat (4) @(posedge mclk);
    endtask

    task automatic conclude();
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard, about 1.6 times the expected run
    initial
    begin
        #2000000;
        failures++;
        conclude();
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        {core_bidi_oe, core_bidi_o, pad_bidi_i, core_out, pad_in} = '0;
        repeat (10) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        i_ctl.idle_reset();
        i_ctl.scan(1'b0, ID_W, '0, dout);
        check("idcode", dout[31:0], ID_EXP);
        check("tdo enable", {i_ctl.oe_miss, tdo_oe}, 2'b00);
        // sample: pins observed in every cell, core path left alone, preload
        new_pins();
        load_ir(IR_SAMPLE);
        pre = rvec();
        i_ctl.scan(1'b0, BSR_LEN, pre, dout);
        check("sample", dout[243:0],
            {core_bidi_oe, core_bidi_o, pad_bidi_i, core_out, pad_in});
        check("core pass",
            {pad_bidi_oe, pad_bidi_o, pad_out, core_bidi_i, core_in},
            {core_bidi_oe, core_bidi_o, core_out, pad_bidi_i, pad_in});
        // every code, reserved ones too: a tail pattern shows the path length
        for (int c = 0; c < 16; c++)
        begin
            load_ir(c[3:0]);
            din = rvec();
            i_ctl.scan(1'b0, chain_len(c[3:0]) + 16, din, dout);
            check("path", dout[chain_len(c[3:0]) +: 16],
                din[15:0]);
            if (chain_len(c[3:0]) == 1)
                check("bypass capture", dout[0], 1'b0);
        end
        // drive modes take pads from the cells; inputs captured meanwhile
        load_ir(IR_SAMPLE);
        pre = rvec();
        i_ctl.scan(1'b0, BSR_LEN, pre, dout);
        foreach (drv[k])
        begin
            load_ir(drv[k]);
            check("drive",
                {pad_bidi_oe, pad_bidi_o, pad_out, pad_out_oe},
                {pre[243:204], pre[183:120], {NUM_OUT{1'b1}}});
            new_pins();
            din = rvec();
            i_ctl.scan(1'b0, BSR_LEN, din, dout);
            check("capture", {dout[203:184], dout[119:0]}, {pad_bidi_i, pad_in});
            pre = din;
        end
        // clamp holds pads while core levels move
        load_ir(IR_CLAMP);
        new_pins();
        repeat (4) @(posedge mclk);
        check("clamp", {pad_bidi_oe, pad_bidi_o, pad_out},
            {pre[243:204], pre[183:120]});
        load_ir(IR_HIGHZ);
        check("highz", {pad_out_oe, pad_bidi_oe}, 84'h0);
        // tms reset, port reset alone, and an update with nothing shifted all give idcode
        for (int m = 0; m < 3; m++)
        begin
            load_ir(IR_BYPASS);
            #7;
            if (m == 1)
            begin
                i_ctl.pulse_trst();
                i_ctl.step(1'b0, 1'b0, bit_seen);
            end
            else if (m == 2)
            begin
                // idle, select-dr, select-ir, capture-ir, exit1-ir, update-ir, idle
                for (int k = 0; k < 6; k++)
                    i_ctl.step(k != 2 && k != 5, 1'b0, bit_seen);
            end
            else
                i_ctl.idle_reset();
            repeat (4) @(posedge mclk);
            check("normal", {pad_out_oe, pad_out}, {{NUM_OUT{1'b1}}, core_out});
            i_ctl.scan(1'b0, ID_W, '0, dout);
            check("idcode", dout[31:0], ID_EXP);
        end
        conclude();
    end
endmodule // tb
